// ===== hdl/sba_pkg.sv
// ==========================================================
// Secondary bus arbiter constants
package sba_pkg;

   // ==========================================================
   // Configuration offsets
   localparam logic [7:0] OFS_TUNING_A = 8'hD9;
   localparam logic [7:0] OFS_TUNING_B = 8'hDA;
   localparam logic [7:0] OFS_ARB_CTRL = 8'hDC;
   localparam logic [7:0] OFS_REQ_MASK = 8'hDD;
   localparam logic [7:0] OFS_TO_STAT = 8'hDE;

   // ==========================================================
   // Values after reset
   localparam logic [7:0] RST_TUNING_A = 8'h00;
   localparam logic [7:0] RST_TUNING_B = 8'h00;
   localparam logic [7:0] RST_ARB_CTRL = 8'h40;
   localparam logic [7:0] RST_REQ_MASK = 8'h00;
   localparam logic [7:0] RST_TO_STAT = 8'h00;

   // Writable bits of the first tuning register, the rest read zero
   localparam logic [7:0] TUNING_A_WMASK = 8'h0F;

   // ==========================================================
   // Field positions
   localparam int CTRL_PARK_BIT = 7;
   localparam int CTRL_BRIDGE_TIER_BIT = 6;
   localparam int CTRL_ZERO_TIER_BIT = 0;
   localparam int MASK_WATCH_EN_BIT = 7;
   localparam int MASK_AUTO_BIT = 6;
   localparam int MASK_ZERO_BLOCK_BIT = 0;
   localparam int STAT_ZERO_TO_BIT = 0;

   // ==========================================================
   // No-start watch: figure in bus clocks, bus clock equals MCLK
   localparam int WATCH_PCI_CLKS = 16;
   localparam int WATCH_CYCLES = WATCH_PCI_CLKS;
   localparam logic [4:0] WATCH_LAST = 5'(WATCH_CYCLES - 1);

   // ==========================================================
   // Bus owner
   typedef enum logic [0:0] {
      OWN_BRIDGE = 1'b0,
      OWN_ZERO = 1'b1
   } sba_owner_t;

endpackage : sba_pkg

// ===== hdl/sba_ctl_if.sv
`timescale 1ns/1ps
// ==========================================================
// Control and event lines between arbiter core, registers, watch
interface sba_ctl_if;
   logic park_on_bridge;
   logic bridge_high;
   logic requester_zero_tier;
   logic no_start_watch_en;
   logic auto_mask_en;
   logic requester_zero_block;
   logic auto_blocked;
   logic bus_idle;
   logic frame_seen;
   logic owner_requesting;
   logic grant_change;
   logic expire;
   logic expire_zero;

   modport regs (
      output park_on_bridge, bridge_high, requester_zero_tier,
      output no_start_watch_en, auto_mask_en, requester_zero_block,
      output auto_blocked,
      input expire_zero
   );
   modport core (
      input park_on_bridge, bridge_high, requester_zero_tier,
      input requester_zero_block, auto_blocked, expire,
      output bus_idle, frame_seen, owner_requesting, grant_change,
      output expire_zero
   );
   modport watch (
      input no_start_watch_en, bus_idle, frame_seen,
      input owner_requesting, grant_change,
      output expire
   );
endinterface : sba_ctl_if

// ===== hdl/sba_watch.sv
`timescale 1ns/1ps
// ==========================================================
// No-start watch: counts idle clocks after a grant
module sba_watch (
   input wire logic clk_in,
   input wire logic rst_n_in,
   sba_ctl_if.watch ctl
);

   logic [4:0] cnt;
   logic started;
   logic [4:0] next_cnt;
   logic next_started;
   logic counting;

   // Count only while enabled, granted master asks, bus idle, no start
   // Grant change stays out of this term: it is itself made from expire
   always_comb begin
      counting = ctl.no_start_watch_en & ctl.owner_requesting &
                 ctl.bus_idle & ~started;
      next_cnt = cnt;
      next_started = started;
      ctl.expire = counting && (cnt == sba_pkg::WATCH_LAST);
      if (ctl.grant_change) begin
         next_cnt = 5'h0_0;
         next_started = 1'b0;
      end else if (ctl.frame_seen) begin
         // Master responded, watch rests until next grant
         next_started = 1'b1;
         next_cnt = 5'h0_0;
      end else if (!counting) begin
         next_cnt = 5'h0_0;
      end else if (ctl.expire) begin
         next_cnt = 5'h0_0;
      end else begin
         next_cnt = cnt + 5'h0_1;
      end
   end

   // State registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= 5'h0_0;
         started <= 1'b0;
      end else begin
         cnt <= next_cnt;
         started <= next_started;
      end
   end

endmodule : sba_watch

// ===== hdl/sba_regs.sv
`timescale 1ns/1ps
// ==========================================================
// Configuration registers of the arbiter
module sba_regs (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic wr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   output logic hit_out,
   sba_ctl_if.regs ctl
);

   logic [7:0] tuning_a;
   logic [7:0] arbitration_control;
   logic [7:0] request_masking;
   logic [7:0] timeout_status;
   logic auto_blk;
   logic [7:0] next_tuning_a;
   logic [7:0] next_arbitration_control;
   logic [7:0] next_request_masking;
   logic [7:0] next_timeout_status;
   logic next_auto_blk;

   // Field outputs
   assign ctl.park_on_bridge = arbitration_control[sba_pkg::CTRL_PARK_BIT];
   assign ctl.bridge_high =
      arbitration_control[sba_pkg::CTRL_BRIDGE_TIER_BIT];
   assign ctl.requester_zero_tier =
      arbitration_control[sba_pkg::CTRL_ZERO_TIER_BIT];
   assign ctl.no_start_watch_en =
      request_masking[sba_pkg::MASK_WATCH_EN_BIT];
   assign ctl.auto_mask_en = request_masking[sba_pkg::MASK_AUTO_BIT];
   assign ctl.requester_zero_block =
      request_masking[sba_pkg::MASK_ZERO_BLOCK_BIT];
   assign ctl.auto_blocked = auto_blk;

   // Write decode; reserved control and mask bits are plain storage, upper tuning A bits are dropped
   always_comb begin
      next_tuning_a = tuning_a;
      next_arbitration_control = arbitration_control;
      next_request_masking = request_masking;
      next_timeout_status = timeout_status;
      next_auto_blk = auto_blk;
      if (wr_in) begin
         case (addr_in)
            sba_pkg::OFS_TUNING_A:
               next_tuning_a = wdata_in & sba_pkg::TUNING_A_WMASK;
            sba_pkg::OFS_ARB_CTRL: next_arbitration_control = wdata_in;
            sba_pkg::OFS_REQ_MASK: begin
               next_request_masking = wdata_in;
               // Rewriting the mask re-enables an auto-masked request
               next_auto_blk = 1'b0;
            end
            sba_pkg::OFS_TO_STAT:
               next_timeout_status = timeout_status & ~wdata_in;
            default: next_tuning_a = tuning_a;
         endcase
      end
      // Set beats a clear in the same cycle
      if (ctl.expire_zero) begin
         next_timeout_status[sba_pkg::STAT_ZERO_TO_BIT] = 1'b1;
         if (ctl.auto_mask_en) begin
            next_auto_blk = 1'b1;
         end
      end
   end

   // Read mux; unmapped offsets read zero with no hit
   always_comb begin
      hit_out = 1'b1;
      case (addr_in)
         sba_pkg::OFS_TUNING_A: rdata_out = tuning_a;
         sba_pkg::OFS_TUNING_B: rdata_out = sba_pkg::RST_TUNING_B;
         sba_pkg::OFS_ARB_CTRL: rdata_out = arbitration_control;
         sba_pkg::OFS_REQ_MASK: rdata_out = request_masking;
         sba_pkg::OFS_TO_STAT: rdata_out = timeout_status;
         default: begin
            rdata_out = 8'h00;
            hit_out = 1'b0;
         end
      endcase
   end

   // Fundamental reset only
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tuning_a <= sba_pkg::RST_TUNING_A;
         arbitration_control <= sba_pkg::RST_ARB_CTRL;
         request_masking <= sba_pkg::RST_REQ_MASK;
         timeout_status <= sba_pkg::RST_TO_STAT;
         auto_blk <= 1'b0;
      end else begin
         tuning_a <= next_tuning_a;
         arbitration_control <= next_arbitration_control;
         request_masking <= next_request_masking;
         timeout_status <= next_timeout_status;
         auto_blk <= next_auto_blk;
      end
   end

endmodule : sba_regs

// ===== hdl/sba_arbiter.sv
`timescale 1ns/1ps
// Function
// - Grant the bus by two priority tiers, rotating within a tier.
// - Park idle bus on the bridge if bit 7 set, else on last master.
// - Control bit 6 puts the bridge in the high tier; reset 40h.
// - Control bit 0 puts requester zero in the high tier; reset low.
// - Mask bit 7 enables a 16-clock no-start time-out.
// - Count from idle after grant; no FRAME in time means dead master.
// - Mask bit 6 blocks request zero automatically after its time-out.
// - Mask bit 0 makes the arbiter ignore request input zero.
// - The request mask register resets to 00h.
// - Tuning registers reset only on the fundamental reset.
// - Fundamental reset is active when link or global reset is.
// - A time-out of requester zero sets a readable status flag; a bridge time-out sets none.
module sba_arbiter (
   input wire logic MCLK_IN,
   input wire logic RESETN_IN,
   input wire logic LINK_SIDE_RSTN_IN,
   input wire logic BRIDGE_REQ_IN,
   input wire logic REQUEST_IN_ZERO_N_IN,
   input wire logic FRAME_N_IN,
   input wire logic IRDY_N_IN,
   input wire logic [7:0] CFG_ADDR_IN,
   input wire logic CFG_WR_IN,
   input wire logic [7:0] CFG_WDATA_IN,
   output logic [7:0] CFG_RDATA_OUT,
   output logic CFG_HIT_OUT,
   output logic BRIDGE_GNT_OUT,
   output logic GRANT_OUT_ZERO_N_OUT
);

   // ==========================================================
   // Reset and shared wiring
   logic fundamental_rst_n;
   sba_ctl_if ctl ();

   // Either reset source drops the whole block
   assign fundamental_rst_n = RESETN_IN & LINK_SIDE_RSTN_IN;

   // ==========================================================
   // Register file and no-start watch
   sba_regs u_regs (
      .clk_in(MCLK_IN),
      .rst_n_in(fundamental_rst_n),
      .addr_in(CFG_ADDR_IN),
      .wr_in(CFG_WR_IN),
      .wdata_in(CFG_WDATA_IN),
      .rdata_out(CFG_RDATA_OUT),
      .hit_out(CFG_HIT_OUT),
      .ctl(ctl.regs)
   );

   sba_watch u_watch (
      .clk_in(MCLK_IN),
      .rst_n_in(fundamental_rst_n),
      .ctl(ctl.watch)
   );

   // ==========================================================
   // Winner selection
   // Tier first, then rotation: the master not served last wins a tie
   function automatic sba_pkg::sba_owner_t pick(
      input logic br_req,
      input logic zero_req,
      input logic br_high,
      input logic zero_high,
      input sba_pkg::sba_owner_t last
   );
      sba_pkg::sba_owner_t w;
      if (br_req && !zero_req) begin
         w = sba_pkg::OWN_BRIDGE;
      end else if (zero_req && !br_req) begin
         w = sba_pkg::OWN_ZERO;
      end else if (br_high != zero_high) begin
         w = br_high ? sba_pkg::OWN_BRIDGE : sba_pkg::OWN_ZERO;
      end else begin
         w = (last == sba_pkg::OWN_BRIDGE) ?
             sba_pkg::OWN_ZERO : sba_pkg::OWN_BRIDGE;
      end
      return w;
   endfunction : pick

   // ==========================================================
   // Arbitration state
   sba_pkg::sba_owner_t owner;
   sba_pkg::sba_owner_t last_served;
   logic bridge_gnt;
   logic zero_gnt_n;
   sba_pkg::sba_owner_t next_owner;
   sba_pkg::sba_owner_t next_last_served;
   sba_pkg::sba_owner_t winner;
   logic next_bridge_gnt;
   logic next_zero_gnt_n;
   logic zero_req;
   logic any_req;
   logic owner_req;
   logic may_switch;

   // Bus state; FRAME and IRDY come from same-clock bus logic
   assign ctl.bus_idle = FRAME_N_IN & IRDY_N_IN;
   assign ctl.frame_seen = ~FRAME_N_IN;

   // Masked requests are dropped before arbitration
   assign zero_req = ~REQUEST_IN_ZERO_N_IN & ~ctl.requester_zero_block &
                     ~ctl.auto_blocked;
   assign any_req = BRIDGE_REQ_IN | zero_req;
   assign owner_req = (owner == sba_pkg::OWN_ZERO) ? zero_req :
                      BRIDGE_REQ_IN;
   assign ctl.owner_requesting = owner_req;
   // Timed-out master is always the one holding the grant
   assign ctl.expire_zero = ctl.expire & (owner == sba_pkg::OWN_ZERO);

   // Grant may move only at idle or once the owner lets go
   assign may_switch = ctl.bus_idle | ~owner_req;

   assign winner = pick(BRIDGE_REQ_IN, zero_req, ctl.bridge_high,
                        ctl.requester_zero_tier, last_served);

   // Next owner and grant lines
   always_comb begin
      next_owner = owner;
      next_last_served = last_served;
      if (ctl.expire) begin
         // Dead master loses the bus unless it is the bridge and zero_req is low; never hand it to a masked zero
         next_owner = (owner == sba_pkg::OWN_BRIDGE && zero_req) ?
                      sba_pkg::OWN_ZERO : sba_pkg::OWN_BRIDGE;
         next_last_served = owner;
      end else if (may_switch) begin
         if (any_req) begin
            next_owner = winner;
            next_last_served = winner;
         end else if (ctl.park_on_bridge) begin
            next_owner = sba_pkg::OWN_BRIDGE;
         end else begin
            next_owner = owner;
         end
      end
      // One-hot by construction: a single owner register
      next_bridge_gnt = (next_owner == sba_pkg::OWN_BRIDGE);
      next_zero_gnt_n = (next_owner != sba_pkg::OWN_ZERO);
   end

   // Tells the watch that a fresh grant starts its count
   assign ctl.grant_change = (next_owner != owner);

   // Arbitration registers; bus starts parked on the bridge
   always_ff @(posedge MCLK_IN or negedge fundamental_rst_n) begin
      if (!fundamental_rst_n) begin
         owner <= sba_pkg::OWN_BRIDGE;
         last_served <= sba_pkg::OWN_BRIDGE;
         bridge_gnt <= 1'b1;
         zero_gnt_n <= 1'b1;
      end else begin
         owner <= next_owner;
         last_served <= next_last_served;
         bridge_gnt <= next_bridge_gnt;
         zero_gnt_n <= next_zero_gnt_n;
      end
   end

   assign BRIDGE_GNT_OUT = bridge_gnt;
   assign GRANT_OUT_ZERO_N_OUT = zero_gnt_n;

endmodule : sba_arbiter

// ===== tb/sba_props.sv
`timescale 1ns/1ps
// ==========
// Checker on the arbiter top ports
module sba_props (
   input wire logic MCLK_IN,
   input wire logic RESETN_IN,
   input wire logic LINK_SIDE_RSTN_IN,
   input wire logic BRIDGE_REQ_IN,
   input wire logic REQUEST_IN_ZERO_N_IN,
   input wire logic FRAME_N_IN,
   input wire logic IRDY_N_IN,
   input wire logic [7:0] CFG_ADDR_IN,
   input wire logic CFG_WR_IN,
   input wire logic [7:0] CFG_WDATA_IN,
   input wire logic [7:0] CFG_RDATA_OUT,
   input wire logic CFG_HIT_OUT,
   input wire logic BRIDGE_GNT_OUT,
   input wire logic GRANT_OUT_ZERO_N_OUT
);
   logic [7:0] ctl;
   logic [7:0] msk;
   logic [4:0] cnt;
   logic stop;
   wire rst_n = RESETN_IN && LINK_SIDE_RSTN_IN;
   wire idle = FRAME_N_IN && IRDY_N_IN;
   wire run = !GRANT_OUT_ZERO_N_OUT && !REQUEST_IN_ZERO_N_IN && idle && msk[7];

   // Register shadows and the unstarted-grant count of requester zero
   always_ff @(posedge MCLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= 8'h40;
         msk <= 8'h00;
         cnt <= 5'h00;
         stop <= 1'b0;
      end else begin
         if (CFG_WR_IN && CFG_ADDR_IN == 8'hDC) ctl <= CFG_WDATA_IN;
         if (CFG_WR_IN && CFG_ADDR_IN == 8'hDD) msk <= CFG_WDATA_IN;
         if ($changed(GRANT_OUT_ZERO_N_OUT)) begin
            stop <= 1'b0;
            cnt <= {4'h0, run};
         end else if (!FRAME_N_IN) begin
            stop <= 1'b1; // A started transfer ends the watch
            cnt <= 5'h00;
         end else if (run && !stop && cnt != 5'h1F) begin
            cnt <= cnt + 5'h01;
         end
      end
   end

   // ==========
   // Properties
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!rst_n);
   sequence s_both;
      idle && BRIDGE_REQ_IN && !REQUEST_IN_ZERO_N_IN && !msk[0] && !msk[7];
   endsequence
   sequence s_none;
      idle && !BRIDGE_REQ_IN && REQUEST_IN_ZERO_N_IN;
   endsequence
   // Bridge won an idle arbitration, so it is the one served last
   sequence s_bridge_served;
      idle && BRIDGE_REQ_IN && !msk[7] ##1 BRIDGE_GNT_OUT;
   endsequence

   a_one_grant: assert property (
      !(BRIDGE_GNT_OUT && !GRANT_OUT_ZERO_N_OUT)) else $error("two grants");
   a_hold_busy: assert property (
      !idle && ((BRIDGE_GNT_OUT && BRIDGE_REQ_IN) || (!GRANT_OUT_ZERO_N_OUT
      && !REQUEST_IN_ZERO_N_IN)) |=> $stable(BRIDGE_GNT_OUT)
      && $stable(GRANT_OUT_ZERO_N_OUT)) else $error("grant moved busy");
   a_zero_blocked: assert property (
      msk[0] && GRANT_OUT_ZERO_N_OUT |=> GRANT_OUT_ZERO_N_OUT)
      else $error("blocked zero granted");
   a_tuning_ro: assert property (
      CFG_ADDR_IN == 8'hDA |-> CFG_RDATA_OUT == 8'h00)
      else $error("tuning b not zero");
   a_bridge_high: assert property (
      s_both ##0 (ctl[6] && !ctl[0]) |=> BRIDGE_GNT_OUT)
      else $error("low tier won");
   a_zero_high: assert property (
      s_both ##0 (ctl[0] && !ctl[6]) |=> !GRANT_OUT_ZERO_N_OUT)
      else $error("high zero lost");
   a_tie_rotates: assert property (
      s_bridge_served ##0 s_both ##0 (ctl[0] == ctl[6])
      |=> !GRANT_OUT_ZERO_N_OUT) else $error("no rotation");
   a_park_bridge: assert property (
      s_none ##0 ctl[7] |-> ##[1:2] BRIDGE_GNT_OUT)
      else $error("not parked on bridge");
   a_park_last: assert property (
      s_none ##0 (!ctl[7] && !GRANT_OUT_ZERO_N_OUT)
      |=> !GRANT_OUT_ZERO_N_OUT) else $error("last master lost bus");
   a_watch_off: assert property (
      !msk[7] && !BRIDGE_REQ_IN && !GRANT_OUT_ZERO_N_OUT
      && !REQUEST_IN_ZERO_N_IN |=> !GRANT_OUT_ZERO_N_OUT)
      else $error("time-out while off");
   a_watch_expire: assert property (
      cnt == 5'h10 |-> ##[0:1] GRANT_OUT_ZERO_N_OUT)
      else $error("no expiry at 16");
endmodule : sba_props

bind sba_arbiter sba_props u_props (
   .MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN),
   .LINK_SIDE_RSTN_IN(LINK_SIDE_RSTN_IN), .BRIDGE_REQ_IN(BRIDGE_REQ_IN),
   .REQUEST_IN_ZERO_N_IN(REQUEST_IN_ZERO_N_IN), .FRAME_N_IN(FRAME_N_IN),
   .IRDY_N_IN(IRDY_N_IN), .CFG_ADDR_IN(CFG_ADDR_IN),
   .CFG_WR_IN(CFG_WR_IN), .CFG_WDATA_IN(CFG_WDATA_IN),
   .CFG_RDATA_OUT(CFG_RDATA_OUT), .CFG_HIT_OUT(CFG_HIT_OUT),
   .BRIDGE_GNT_OUT(BRIDGE_GNT_OUT),
   .GRANT_OUT_ZERO_N_OUT(GRANT_OUT_ZERO_N_OUT));

// ===== tb/sba_master.sv
`timescale 1ns/1ps
// ==========
// Requester zero: asks, waits lag granted idle clocks, one transfer
module sba_master (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic go_in,
   input wire logic [4:0] lag_in,
   input wire logic gnt_n_in,
   output logic req_n_out,
   output logic frame_n_out,
   output logic irdy_n_out
);
   logic [4:0] wait_cnt;
   logic [1:0] phase;
   wire idle = frame_n_out && irdy_n_out;

   // Bus lines are pulled up, so a released line reads high
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_n_out <= 1'b1;
         frame_n_out <= 1'b1;
         irdy_n_out <= 1'b1;
         wait_cnt <= 5'h00;
         phase <= 2'h0;
      end else if (phase == 2'h1) begin
         frame_n_out <= 1'b1; // Last data phase
         req_n_out <= 1'b1;
         phase <= 2'h2;
      end else if (phase == 2'h2) begin
         irdy_n_out <= 1'b1;
         phase <= 2'h0;
      end else if (gnt_n_in || req_n_out || !idle) begin
         req_n_out <= !go_in;
         wait_cnt <= 5'h00;
      end else if (wait_cnt == lag_in) begin
         frame_n_out <= 1'b0;
         irdy_n_out <= 1'b0;
         phase <= 2'h1;
      end else begin
         wait_cnt <= wait_cnt + 5'h01; // Slow start, may time out
      end
   end
endmodule : sba_master

// ===== tb/sba_arbiter_tb.sv
`timescale 1ns/1ps
// ==========
// Bench for the secondary bus arbiter
module sba_arbiter_tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic lrstn = 1'b1;
   logic breq = 1'b0;
   logic go = 1'b0;
   logic [4:0] lag = 5'h00;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic hit, bgnt, g0n, req0n, frn, irn;
   int n_errors = 0;
   int checks = 0;
   int n;
   logic [7:0] ofs [4] = '{8'hD9, 8'hDA, 8'hDC, 8'hDD};
   logic [7:0] dft [4] = '{8'h00, 8'h00, 8'h40, 8'h00};
   logic [7:0] tie [3] = '{8'h41, 8'h01, 8'h00};

   always #20 clk = ~clk;

   sba_master u_zero (.clk_in(clk), .rst_n_in(rstn && lrstn), .go_in(go),
      .lag_in(lag), .gnt_n_in(g0n), .req_n_out(req0n),
      .frame_n_out(frn), .irdy_n_out(irn));
   sba_arbiter DUT (.MCLK_IN(clk), .RESETN_IN(rstn),
      .LINK_SIDE_RSTN_IN(lrstn), .BRIDGE_REQ_IN(breq),
      .REQUEST_IN_ZERO_N_IN(req0n), .FRAME_N_IN(frn), .IRDY_N_IN(irn),
      .CFG_ADDR_IN(addr), .CFG_WR_IN(wr), .CFG_WDATA_IN(wdata),
      .CFG_RDATA_OUT(rdata), .CFG_HIT_OUT(hit), .BRIDGE_GNT_OUT(bgnt),
      .GRANT_OUT_ZERO_N_OUT(g0n));

   // ==========
   // Tasks
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   task automatic cmp(input string what, input logic [7:0] e,
      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : cmp

   // One-cycle write strobe, launched off the falling edge
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wrr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      #1 cmp("read data", e, rdata);
   endtask : rd

   // Bounded wait on zero's request (sel 1) or grant (sel 0)
   task automatic wt(input bit sel, input logic lvl, input int lim);
      n = 0;
      while ((sel ? req0n : g0n) !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
      if ((sel ? req0n : g0n) !== lvl) begin
         cmp("wait level", 8'(lvl), 8'(sel ? req0n : g0n));
         finish_test();
      end
   endtask : wt

   task automatic chk_dft();
      for (int i = 0; i < 4; i++) begin
         rd(ofs[i], dft[i]);
      end
   endtask : chk_dft

   // ==========
   // Main sequence
   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      cmp("bridge grant", 8'h01, 8'(bgnt));
      chk_dft();
      rd(8'h00, 8'h00);
      cmp("hit", 8'h00, 8'(hit));
      wrr(8'hDC, 8'h7E);
      rd(8'hDC, 8'h7E);
      cmp("hit", 8'h01, 8'(hit));
      wrr(8'hDD, 8'h3E);
      rd(8'hDD, 8'h3E);
      wrr(8'hDA, 8'h55);
      rd(8'hDA, 8'h00);
      wrr(8'hDD, 8'h00);
      wrr(8'hDC, 8'h40);
      // Bridge high keeps the bus, low tier wins once it lets go
      breq = 1'b1;
      go = 1'b1;
      repeat (6) @(negedge clk);
      cmp("zero grant", 8'h01, 8'(g0n));
      breq = 1'b0;
      wt(0, 1'b0, 4);
      wt(1, 1'b1, 40);
      go = 1'b0;
      repeat (4) @(negedge clk);
      cmp("zero parked", 8'h00, 8'(g0n));
      wrr(8'hDC, 8'hC0);
      wt(0, 1'b1, 4);
      cmp("bridge parked", 8'h01, 8'(bgnt));
      // Ties rotate; zero high beats a low bridge
      foreach (tie[i]) begin
         wrr(8'hDC, tie[i]);
         breq = 1'b1;
         go = 1'b1;
         wt(0, 1'b0, 4);
         wt(1, 1'b1, 40);
         go = 1'b0;
         wt(0, 1'b1, 4);
         breq = 1'b0;
      end
      // Masked request is ignored until unmasked
      wrr(8'hDD, 8'h01);
      go = 1'b1;
      repeat (20) @(negedge clk);
      cmp("masked zero", 8'h01, 8'(g0n));
      wrr(8'hDD, 8'h00);
      wt(0, 1'b0, 4);
      wt(1, 1'b1, 40);
      go = 1'b0;
      // Dead master: expiry, status flag, automatic block
      // Park on the bridge first: a parked zero gets no fresh grant
      wrr(8'hDC, 8'hC0);
      wrr(8'hDD, 8'hC0);
      lag = 5'h1F;
      go = 1'b1;
      wt(0, 1'b0, 4);
      wt(0, 1'b1, 24);
      cmp("expiry clocks", 8'h01, 8'(n == 16 || n == 17));
      rd(8'hDE, 8'h01);
      repeat (20) @(negedge clk);
      cmp("auto blocked", 8'h01, 8'(g0n));
      wrr(8'hDD, 8'h80);
      wt(0, 1'b0, 4);
      wt(0, 1'b1, 24);
      lag = 5'h02;
      wt(0, 1'b0, 4);
      wt(1, 1'b1, 40);
      go = 1'b0;
      // Link-side reset alone restores the defaults read at D9, DA, DC and DD
      wrr(8'hD9, 8'h05);
      wrr(8'hDC, 8'hC1);
      lrstn = 1'b0;
      repeat (2) @(negedge clk);
      lrstn = 1'b1;
      chk_dft();
      finish_test();
   end
endmodule : sba_arbiter_tb
